/* File: logic/frt_pkg.sv */
// constants shared by the coast-stop and external-fault control block
package frt_pkg;
    // ====================================================================
    // clock and timing
    // ====================================================================
    localparam int CLK_PERIOD_NS = 10; // 100 MHz system clock
    localparam int HOLDOFF_UNIT_NS = 1000000; // one holdoff step is 1 ms
    localparam int HOLDOFF_UNIT_CYC = HOLDOFF_UNIT_NS / CLK_PERIOD_NS; // cycles per step
    localparam int NUM_INPUTS = 5; // multifunction inputs
    localparam int FUNC_W = 6; // width of one function code field
    localparam int SYNC_FILL_CYC = 2; // cycles until synchronised pins are valid

    // ====================================================================
    // register byte offsets
    // ====================================================================
    localparam logic [7:0] REG_CTRL = 8'h00; // start point and power-up guard
    localparam logic [7:0] REG_HOLDOFF = 8'h04; // restart holdoff in 1 ms steps
    localparam logic [7:0] REG_POLARITY = 8'h08; // one invert bit per input
    localparam logic [7:0] REG_FUNC = 8'h0c; // five 6-bit function codes
    localparam logic [7:0] REG_STATUS = 8'h10; // live state, read only
    localparam logic [7:0] REG_IRQ_STAT = 8'h14; // sticky events, read only
    localparam logic [7:0] REG_IRQ_EN = 8'h18; // event enables
    localparam logic [7:0] REG_IRQ_CLR = 8'h1c; // write one to clear, write only
    localparam logic [7:0] REG_KEY_RESET = 8'h20; // write bit 0 for a keypad reset

    // ====================================================================
    // field positions and reset values
    // ====================================================================
    localparam int CTRL_START_SPEED_BIT = 0; // 1: restart from present speed
    localparam int CTRL_GUARD_BIT = 1; // 1: power-up autostart guard on
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] HOLDOFF_RST = 16'h0000;
    localparam logic [4:0] POLARITY_RST = 5'h00;
    localparam logic [29:0] FUNC_RST = 30'h00000000;
    localparam int IRQ_W = 4; // events: fault trip, guard trip, coast, resume
    localparam int IRQ_EXT_BIT = 0;
    localparam int IRQ_GUARD_BIT = 1;
    localparam int IRQ_COAST_BIT = 2;
    localparam int IRQ_RESUME_BIT = 3;

    // ====================================================================
    // function codes and error indications
    // ====================================================================
    localparam logic [5:0] FN_COAST_STOP = 6'h0b; // code 11
    localparam logic [5:0] FN_EXT_FAULT = 6'h0c; // code 12
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_EXT_FAULT = 8'h0c; // external fault indication
    localparam logic [7:0] ERR_GUARD = 8'h0d; // power-up guard indication

    // ====================================================================
    // control states
    // ====================================================================
    typedef enum logic [2:0] {
        FRT_STOP,
        FRT_RUN,
        FRT_COAST,
        FRT_HOLDOFF,
        FRT_TRIP
    } frt_state_e;
endpackage : frt_pkg

/* File: logic/frt_ctrl.sv */
// coast-stop and external-fault trip control with register port and interrupt
//
// Contract
// - coast input active switches drive off
// - coast release resumes only with run asserted
// - restart from zero or present speed
// - holdoff delays restart, zero means none
// - per-input polarity invert setting
// - code 11 coast, code 12 fault
// - fault rising edge latches trip, shows error
// - fault release neither trips nor clears
// - trip stays latched after input drops
// - only reset leaves a fault trip, into stop; a guard trip also ends when run drops
// - trip raises alarm at once, coasts
// - reset clears alarm; release with run restarts
// - guard needs fresh run edge after trip
// - guard: run at power-up trips instead
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module frt_ctrl
    import frt_pkg::*;
#(
    parameter int HOLDOFF_TICK_CYC = HOLDOFF_UNIT_CYC // shorten in simulation
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [4:0] mf_input_i, // field switches, asynchronous
    input wire logic run_cmd_i, // run command pin, asynchronous
    input wire logic reset_terminal_input_i, // reset terminal, asynchronous
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic drive_enable_o, // power stage on
    output logic restart_from_speed_o, // start point for the present run
    output logic alarm_o,
    output logic [7:0] error_code_o,
    output logic irq_o
);
    // ====================================================================
    // input synchronisers
    // ====================================================================
    logic [6:0] sync1_q; // first stage, read only by the second
    logic [6:0] sync2_q; // safe copies
    logic [4:0] pin_s;
    logic run_s;
    logic rst_term_s;

    // two flops per pin before any logic looks at it
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else begin
            sync1_q <= {reset_terminal_input_i, run_cmd_i, mf_input_i};
            sync2_q <= sync1_q;
        end
    end
    assign pin_s = sync2_q[4:0];
    assign run_s = sync2_q[5];
    assign rst_term_s = sync2_q[6];

    // ====================================================================
    // configuration registers
    // ====================================================================
    logic [1:0] ctrl_q; // start point select and guard enable
    logic [15:0] holdoff_q; // restart holdoff time in 1 ms steps
    logic [4:0] polarity_q; // input polarity settings
    logic [29:0] func_q; // input function assignments
    logic [IRQ_W-1:0] irq_en_q;
    logic key_reset_q; // one-cycle keypad reset pulse

    // software writes, one register per offset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q <= CTRL_RST;
            holdoff_q <= HOLDOFF_RST;
            polarity_q <= POLARITY_RST;
            func_q <= FUNC_RST;
            irq_en_q <= '0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CTRL: ctrl_q <= reg_wdata_i[1:0];
                REG_HOLDOFF: holdoff_q <= reg_wdata_i[15:0];
                REG_POLARITY: polarity_q <= reg_wdata_i[4:0];
                REG_FUNC: func_q <= reg_wdata_i[29:0];
                REG_IRQ_EN: irq_en_q <= reg_wdata_i[IRQ_W-1:0];
                default: ; // read-only and unmapped offsets ignore writes
            endcase
        end
    end

    // keypad reset is a pulse so it acts like a short press
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            key_reset_q <= 1'b0;
        end else begin
            key_reset_q <= reg_wr_i && (reg_addr_i == REG_KEY_RESET) && reg_wdata_i[0];
        end
    end

    // ====================================================================
    // input function mapping
    // ====================================================================
    logic [4:0] act; // input after polarity
    logic [4:0] is_coast;
    logic [4:0] is_ext;
    logic coast_act;
    logic ext_act;

    // each input is inverted on request, then decoded by its code
    for (genvar gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
        assign act[gi] = pin_s[gi] ^ polarity_q[gi];
        assign is_coast[gi] = act[gi] && (func_q[gi*FUNC_W +: FUNC_W] == FN_COAST_STOP);
        assign is_ext[gi] = act[gi] && (func_q[gi*FUNC_W +: FUNC_W] == FN_EXT_FAULT);
    end
    assign coast_act = |is_coast;
    assign ext_act = |is_ext;

    // ====================================================================
    // edges, reset command and power-up window
    // ====================================================================
    logic ext_prev_q;
    logic ext_edge;
    logic reset_cmd;
    logic reset_prev_q;
    logic reset_release;
    logic [1:0] pwr_cnt_q; // counts the synchroniser fill after power-up
    logic pwr_chk; // the one cycle the guard looks at the run pin
    logic guard_en;
    logic armed_q; // run went low since the last trip or reset release

    assign reset_cmd = rst_term_s || key_reset_q;
    assign reset_release = reset_prev_q && !reset_cmd;
    assign ext_edge = ext_act && !ext_prev_q;
    assign pwr_chk = (pwr_cnt_q == 2'(SYNC_FILL_CYC));
    assign guard_en = ctrl_q[CTRL_GUARD_BIT];

    // history of the levels that need edges
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_prev_q <= 1'b0;
            reset_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_act;
            reset_prev_q <= reset_cmd;
        end
    end

    // stops at 3 so the guard check fires once per power-up
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_cnt_q <= 2'h0;
        end else if (pwr_cnt_q != 2'h3) begin
            pwr_cnt_q <= pwr_cnt_q + 2'h1;
        end
    end

    // ====================================================================
    // holdoff timer
    // ====================================================================
    frt_state_e st_q;
    frt_state_e st_d;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [15:0] hold_cnt_q;

    assign tick = (tick_cnt_q == 32'(HOLDOFF_TICK_CYC - 1));

    // free-running 1 ms prescaler; first step may be short by up to 1 ms
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // loaded when the coast ends, counted down in steps
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_cnt_q <= 16'h0;
        end else if (st_q == FRT_COAST) begin
            hold_cnt_q <= holdoff_q;
        end else if (st_q == FRT_HOLDOFF && tick && hold_cnt_q != 16'h0) begin
            hold_cnt_q <= hold_cnt_q - 16'h1;
        end
    end

    // ====================================================================
    // control state machine
    // ====================================================================
    logic start_ok;
    assign start_ok = run_s && !coast_act && (!guard_en || armed_q);

    // reset beats a fault edge; a fault edge beats every run condition
    always_comb begin
        st_d = st_q;
        if (reset_cmd) begin
            st_d = FRT_STOP;
        end else if (ext_edge) begin
            st_d = FRT_TRIP;
        end else if (pwr_chk && guard_en && run_s) begin
            st_d = FRT_TRIP;
        end else if (reset_release) begin
            // guarded start waits for a fresh run edge
            st_d = (run_s && !coast_act && !guard_en) ? FRT_RUN : FRT_STOP;
        end else begin
            case (st_q)
                FRT_STOP: begin
                    if (start_ok) st_d = FRT_RUN;
                end
                FRT_RUN: begin
                    if (coast_act) st_d = FRT_COAST;
                    else if (!run_s) st_d = FRT_STOP;
                end
                FRT_COAST: begin
                    if (coast_act) st_d = FRT_COAST;
                    else if (!run_s) st_d = FRT_STOP;
                    else if (holdoff_q == 16'h0) st_d = FRT_RUN;
                    else st_d = FRT_HOLDOFF;
                end
                FRT_HOLDOFF: begin
                    if (coast_act) st_d = FRT_COAST;
                    else if (!run_s) st_d = FRT_STOP;
                    else if (hold_cnt_q == 16'h0) st_d = FRT_RUN;
                end
                FRT_TRIP: begin
                    // a fault trip waits for reset; a guard trip also ends when run drops
                    if (error_code_o == ERR_GUARD && !run_s) st_d = FRT_STOP;
                end
                default: st_d = FRT_STOP;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= FRT_STOP;
        end else begin
            st_q <= st_d;
        end
    end

    // arming for the guard: cleared by a trip or a reset release while run is high, set when run is low
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed_q <= 1'b0;
        end else if (!run_s) begin
            armed_q <= 1'b1;
        end else if (st_d == FRT_TRIP || reset_release) begin
            armed_q <= 1'b0;
        end
    end

    // ====================================================================
    // outputs
    // ====================================================================
    logic drive_q;
    logic speed_q;
    logic alarm_q;
    logic [7:0] err_q;

    // drive follows only the run state, so a trip always forces it off
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= (st_d == FRT_RUN);
        end
    end

    // start point latched at the moment of resumption
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            speed_q <= 1'b0;
        end else if (st_d == FRT_RUN && st_q != FRT_RUN) begin
            speed_q <= (st_q == FRT_COAST || st_q == FRT_HOLDOFF)
                       && ctrl_q[CTRL_START_SPEED_BIT];
        end
    end

    // alarm and error indication; a fault edge during a guard trip shows the fault
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_q <= 1'b0;
            err_q <= ERR_NONE;
        end else if (st_d == FRT_TRIP && (st_q != FRT_TRIP || ext_edge)) begin
            alarm_q <= 1'b1;
            err_q <= ext_edge ? ERR_EXT_FAULT : ERR_GUARD;
        end else if (st_d != FRT_TRIP) begin
            alarm_q <= 1'b0;
            err_q <= ERR_NONE;
        end
    end

    assign drive_enable_o = drive_q;
    assign restart_from_speed_o = speed_q;
    assign alarm_o = alarm_q;
    assign error_code_o = err_q;

    // ====================================================================
    // interrupts
    // ====================================================================
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;

    assign irq_ev[IRQ_EXT_BIT] = (st_d == FRT_TRIP) && ext_edge;
    assign irq_ev[IRQ_GUARD_BIT] = (st_d == FRT_TRIP) && (st_q != FRT_TRIP) && !ext_edge;
    assign irq_ev[IRQ_COAST_BIT] = (st_d == FRT_COAST) && (st_q == FRT_RUN);
    assign irq_ev[IRQ_RESUME_BIT] = (st_d == FRT_RUN)
                                    && (st_q == FRT_COAST || st_q == FRT_HOLDOFF);
    assign irq_clr = (reg_wr_i && reg_addr_i == REG_IRQ_CLR) ? reg_wdata_i[IRQ_W-1:0] : '0;

    // an event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
        end
    end
    assign irq_o = |(irq_stat_q & irq_en_q);

    // ====================================================================
    // register read port
    // ====================================================================
    logic [31:0] rdata_q;

    // data valid the cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REG_CTRL: rdata_q <= {30'h0, ctrl_q};
                REG_HOLDOFF: rdata_q <= {16'h0, holdoff_q};
                REG_POLARITY: rdata_q <= {27'h0, polarity_q};
                REG_FUNC: rdata_q <= {2'h0, func_q};
                REG_STATUS: rdata_q <= {16'h0, err_q, 3'h0, armed_q,
                                        st_q == FRT_HOLDOFF, st_q == FRT_COAST,
                                        alarm_q, drive_q};
                REG_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
                REG_IRQ_EN: rdata_q <= {28'h0, irq_en_q};
                default: rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end
    assign reg_rdata_o = rdata_q;

    // ====================================================================
    // checks
    // ====================================================================
    sequence s_coast_released;
        st_q == FRT_COAST && !coast_act && run_s && !reset_cmd && !ext_edge;
    endsequence
    sequence s_guarded_release;
        reset_release && guard_en && !ext_edge;
    endsequence

    chk_coast_cuts: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        coast_act |=> !drive_q) else $error("drive on while coast input active");
    chk_resume_run: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(drive_q) |-> $past(run_s)) else $error("drive started without run");
    chk_start_point: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(drive_q) && $past(st_q == FRT_COAST || st_q == FRT_HOLDOFF)
        |-> speed_q == $past(ctrl_q[CTRL_START_SPEED_BIT])) else $error("wrong start point");
    chk_zero_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_coast_released ##0 (holdoff_q == 16'h0) |=> drive_q) else $error("zero holdoff delayed");
    chk_hold_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_coast_released ##0 (holdoff_q != 16'h0) |=> !drive_q) else $error("holdoff skipped");
    chk_trip_latch: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        ext_edge && !reset_cmd |=> alarm_q && err_q == ERR_EXT_FAULT && !drive_q)
        else $error("fault edge not latched");
    chk_trip_holds: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        alarm_q && err_q == ERR_EXT_FAULT && !reset_cmd |=> alarm_q)
        else $error("fault trip dropped without reset");
    chk_trip_reset: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        reset_cmd |=> !alarm_q && err_q == ERR_NONE && !drive_q) else $error("reset left trip");
    chk_trip_off: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        alarm_q |-> !drive_q) else $error("drive on during trip");
    chk_guard_power: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        pwr_chk && guard_en && run_s && !reset_cmd && !ext_edge
        |=> alarm_q && err_q == ERR_GUARD) else $error("guard trip missing");
    chk_guard_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_guarded_release |=> !drive_q) else $error("guarded restart without run edge");
endmodule : frt_ctrl

/* File: bench/frt_field_model.sv */
// field switch model: the contacts wired to the five multifunction inputs
`timescale 1ns/1ps
module frt_field_model (
    input wire logic coast_lvl_i, // coast-stop contact closed
    input wire logic fault_lvl_i, // external fault contact closed
    input wire logic [2:0] spare_i, // unassigned contacts, random chatter
    output logic [4:0] mf_input_o // levels seen at the block's pins
);
    // ==================================================================
    // pin wiring
    // ==================================================================
    // contacts are plain levels; no extra delay so pin timing stays as noted
    assign mf_input_o = {spare_i, fault_lvl_i, coast_lvl_i};
endmodule : frt_field_model

/* File: bench/tb_top.sv */
// self-checking bench for the coast-stop and external-fault control block
`timescale 1ns/1ps
module tb_top;
    import frt_pkg::*;
    localparam int TICK = 10; // shortened holdoff step
    localparam logic [7:0] ZERO_ADDRS [5] = '{REG_CTRL, REG_HOLDOFF, REG_POLARITY, REG_FUNC, 8'h24};
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic coast = 1'b0, fault = 1'b0, run = 1'b0, rst_term = 1'b0; // stimulus levels
    logic [2:0] spare = 3'h0; // chatter on unassigned inputs
    logic [4:0] mf_input;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0, rd_s = 1'b0, rd_seen = 1'b0;
    logic [31:0] rdata, seed = 32'h4e6c;
    logic drive_en, from_speed, alarm, irq;
    logic [7:0] err_code;
    logic [31:0] exp_q [$], mask_q [$]; // expected read data and compare masks
    int miscompares = 0, comparisons = 0;

    // ==================================================================
    // clock, partner and design
    // ==================================================================
    always #5 clk_sys_i = ~clk_sys_i;
    frt_field_model frt_field_model_i (.coast_lvl_i(coast), .fault_lvl_i(fault),
        .spare_i(spare), .mf_input_o(mf_input));
    frt_ctrl #(.HOLDOFF_TICK_CYC(TICK)) frt_ctrl_i (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .mf_input_i(mf_input), .run_cmd_i(run),
        .reset_terminal_input_i(rst_term), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .drive_enable_o(drive_en),
        .restart_from_speed_o(from_speed), .alarm_o(alarm), .error_code_o(err_code),
        .irq_o(irq));

    // ==================================================================
    // random chatter and helpers
    // ==================================================================
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // unassigned inputs toggle freely; they must never reach the control state
    always @(posedge clk_sys_i) begin
        seed <= xorshift(seed);
        spare <= seed[2:0];
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg
    // the read's expectation is queued here and compared by the watcher
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m);
        @(posedge clk_sys_i);
        addr <= a;
        rd_s <= 1'b1;
        exp_q.push_back(want);
        mask_q.push_back(m);
        @(posedge clk_sys_i);
        rd_s <= 1'b0;
    endtask : rd_reg
    // read data stand only in the cycle after the strobe, so sample mid-cycle
    always @(posedge clk_sys_i) rd_seen <= rd_s;
    always @(negedge clk_sys_i) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(rdata & mask_q.pop_front(), exp_q.pop_front());
        end
    end
    task automatic end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        tick(20000);
        miscompares++;
        end_sim();
    end

    // ==================================================================
    // main sequence; pins need 3 edges to reach outputs, so settle with 4
    // ==================================================================
    initial begin
        tick(5);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd_reg(ZERO_ADDRS[i], 32'h0, 32'hffffffff);
        end
        wr_reg(REG_IRQ_STAT, 32'hf);
        rd_reg(REG_IRQ_STAT, 32'h0, 32'hf);
        wr_reg(REG_FUNC, {20'h0, FN_EXT_FAULT, FN_COAST_STOP});
        $display("test registers done");
        run <= 1'b1;
        tick(4);
        check(32'(drive_en), 32'h1);
        check(32'(from_speed), 32'h0);
        coast <= 1'b1;
        tick(4);
        check(32'(drive_en), 32'h0);
        rd_reg(REG_IRQ_STAT, 32'h4, 32'h4);
        run <= 1'b0;
        coast <= 1'b0;
        tick(4);
        check(32'(drive_en), 32'h0);
        run <= 1'b1;
        tick(4);
        wr_reg(REG_CTRL, 32'h1);
        coast <= 1'b1;
        tick(4);
        coast <= 1'b0;
        tick(4);
        check(32'(drive_en), 32'h1);
        check(32'(from_speed), 32'h1);
        wr_reg(REG_HOLDOFF, 32'h3);
        coast <= 1'b1;
        tick(4);
        coast <= 1'b0;
        tick(4);
        // first step may be short, but two full steps must still be pending
        check(32'(drive_en), 32'h0);
        for (int i = 0; i < 40 && drive_en !== 1'b1; i++) tick(1);
        check(32'(drive_en), 32'h1);
        wr_reg(REG_HOLDOFF, 32'h0);
        wr_reg(REG_CTRL, 32'h0);
        $display("test coast done");
        wr_reg(REG_POLARITY, 32'h1);
        tick(4);
        check(32'(drive_en), 32'h0);
        coast <= 1'b1;
        tick(4);
        check(32'(drive_en), 32'h1);
        coast <= 1'b0;
        wr_reg(REG_POLARITY, 32'h0);
        tick(6);
        $display("test polarity done");
        wr_reg(REG_IRQ_CLR, 32'hf);
        wr_reg(REG_IRQ_EN, 32'h1);
        fault <= 1'b1;
        tick(4);
        check(32'(alarm), 32'h1);
        check(32'(err_code), 32'(ERR_EXT_FAULT));
        check(32'(drive_en), 32'h0);
        check(32'(irq), 32'h1);
        rd_reg(REG_STATUS, {16'h0, ERR_EXT_FAULT, 8'h02}, 32'hff03);
        fault <= 1'b0;
        coast <= 1'b1;
        tick(4);
        coast <= 1'b0;
        tick(4);
        check(32'(alarm), 32'h1);
        check(32'(drive_en), 32'h0);
        wr_reg(REG_IRQ_EN, 32'h0);
        tick(2);
        check(32'(irq), 32'h0);
        wr_reg(REG_IRQ_EN, 32'h1);
        wr_reg(REG_IRQ_CLR, 32'h1);
        tick(2);
        check(32'(irq), 32'h0);
        rst_term <= 1'b1;
        tick(4);
        check(32'(alarm), 32'h0);
        check(32'(err_code), 32'(ERR_NONE));
        check(32'(drive_en), 32'h0);
        rst_term <= 1'b0;
        tick(5);
        check(32'(drive_en), 32'h1);
        $display("test fault done");
        wr_reg(REG_CTRL, 32'h2);
        fault <= 1'b1;
        tick(4);
        check(32'(alarm), 32'h1);
        fault <= 1'b0;
        wr_reg(REG_KEY_RESET, 32'h1);
        tick(4);
        check(32'(alarm), 32'h0);
        tick(4);
        check(32'(drive_en), 32'h0);
        // operator supplies a fresh run edge after the trip is cleared
        run <= 1'b0;
        tick(4);
        run <= 1'b1;
        tick(4);
        check(32'(drive_en), 32'h1);
        $display("test guard done");
        // power cycle with run held and the guard set at once: trip, no start
        reset_n_i <= 1'b0;
        tick(2);
        reset_n_i <= 1'b1;
        wr_reg(REG_CTRL, 32'h2);
        tick(4);
        check(32'(err_code), 32'(ERR_GUARD));
        check(32'(alarm), 32'h1);
        check(32'(drive_en), 32'h0);
        run <= 1'b0;
        tick(4);
        check(32'(alarm), 32'h0);
        $display("test power-up guard done");
        end_sim();
    end
endmodule : tb_top
